/* core/fbcf_pkg.sv */
// Constants and types for the parallel NOR flash bus controller.
// Assumes a single 125 MHz clock on the controller side.
// Operation
// - Read: chip-select, output-enable low, write-strobe high
// - Host holds output-enable high during writes
// - Only one bank programs or erases at once
// - Auto Select: three writes, last to bank
package fbcf_pkg;
    localparam int CLK_NS       = 8;
    localparam int GLITCH_NS    = 5;
    localparam int PULSE_RAW    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
    localparam int AUTO_SBY_NS  = 300;
    localparam int AUTO_SBY_CYC = (AUTO_SBY_NS + CLK_NS - 1) / CLK_NS;
    localparam int ABORT_NS     = 10000;
    localparam int ABORT_CYC    = (ABORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W        = 11;
    localparam int SBY_W        = 6;
    localparam int ADDR_W       = 21;
    localparam int DATA_W       = 16;
    localparam int SYNC_STAGES  = 3;
    localparam int BANK_HI      = 20;
    localparam int BANK_LO      = 19;

    typedef enum logic [2:0] {
        FBCF_CMD_READ    = 3'h0,
        FBCF_CMD_WRITE   = 3'h1,
        FBCF_CMD_RESET   = 3'h2,
        FBCF_CMD_RESET3  = 3'h3,
        FBCF_CMD_AUTOSEL = 3'h4,
        FBCF_CMD_CFI     = 3'h5,
        FBCF_CMD_SIGREAD = 3'h6
    } fbcf_cmd_t;

    typedef enum logic [2:0] {
        FBCF_ST_IDLE   = 3'h0,
        FBCF_ST_LOAD   = 3'h1,
        FBCF_ST_STROBE = 3'h2,
        FBCF_ST_HOLD   = 3'h3,
        FBCF_ST_GAP    = 3'h4,
        FBCF_ST_ABORT  = 3'h5
    } fbcf_state_t;
endpackage : fbcf_pkg

/* core/fbcf_sync.sv */
// Three-stage synchroniser for pins read back from the flash.
// Assumes inputs asynchronous to mclk_in.
`timescale 1ns/100ps
module fbcf_sync
    import fbcf_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_nxt;

    // Accept a change only once stages two and three agree
    always_comb begin
        q_nxt = (s2_r == s3_r) ? s3_r : q_out;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            q_out <= '0;
        end else begin
            s1_r  <= d_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            q_out <= q_nxt;
        end
    end
endmodule : fbcf_sync

/* core/fbcf_host.sv */
// Host controller driving a four-bank parallel NOR flash over its pins.
// Assumes user requests on mclk_in; flash data pins are asynchronous.
`timescale 1ns/100ps
module fbcf_host
    import fbcf_pkg::*;
#(
    parameter int         READ_WAIT_CYC = 16,
    parameter logic [20:0] U1_X16       = 21'h0_0555,
    parameter logic [20:0] U2_X16       = 21'h0_02aa,
    parameter logic [20:0] U1_X8        = 21'h0_0aaa,
    parameter logic [20:0] U2_X8        = 21'h0_0555,
    parameter logic [20:0] CFI_X16      = 21'h0_0055,
    parameter logic [20:0] CFI_X8       = 21'h0_00aa,
    parameter logic [7:0]  D_UNLOCK1    = 8'haa,
    parameter logic [7:0]  D_UNLOCK2    = 8'h55,
    parameter logic [7:0]  D_RESET      = 8'hf0,
    parameter logic [7:0]  D_AUTOSEL    = 8'h90,
    parameter logic [7:0]  D_CFI        = 8'h98
) (
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    // User request port
    input  wire logic              req_in,
    input  wire logic [2:0]        cmd_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              lsb_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              byte_mode_in,
    input  wire logic              wp_in,
    output logic                   ready_out,
    output logic                   done_out,
    output logic      [DATA_W-1:0] rdata_out,
    output logic                   standby_out,
    // Flash pins
    output logic                   ce_n_out,
    output logic                   oe_n_out,
    output logic                   we_n_out,
    output logic      [ADDR_W-1:0] addr_out,
    output logic      [DATA_W-1:0] dq_out,
    output logic      [DATA_W-1:0] dq_oe_out,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic                   byte_n_out,
    output logic                   wp_n_out,
    output logic                   rst_n_out,
    output logic                   sig_hv_out
);
    generate
        if (READ_WAIT_CYC < SYNC_STAGES + 1 || READ_WAIT_CYC > 255) begin : g_chk
            $error("READ_WAIT_CYC out of range");
        end
    endgenerate

    localparam logic [CNT_W-1:0] READ_LAST  = CNT_W'(READ_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(WE_PULSE_CYC);
    localparam logic [CNT_W-1:0] ABORT_LAST = CNT_W'(ABORT_CYC - 1);
    localparam logic [SBY_W-1:0] SBY_LAST   = SBY_W'(AUTO_SBY_CYC - 1);

    fbcf_state_t       st_r, st_nxt;
    fbcf_cmd_t         cmd_r, cmd_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [SBY_W-1:0]  idle_r, idle_nxt;
    logic [1:0]        step_r, step_nxt;
    logic [ADDR_W-1:0] a_r, a_nxt;
    logic              lsb_r, lsb_nxt;
    logic [DATA_W-1:0] wd_r, wd_nxt;
    logic              ce_n_nxt, oe_n_nxt, we_n_nxt, hv_nxt;
    logic [ADDR_W-1:0] aout_nxt;
    logic [DATA_W-1:0] dqo_nxt, dqoe_nxt, rd_nxt;
    logic              rdy_nxt, done_nxt, sby_nxt;
    logic [DATA_W-1:0] dq_sync;
    logic              is_read, last_step;

    fbcf_sync #(.W(DATA_W)) u_dq_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .d_in    (dq_in),
        .q_out   (dq_sync)
    );

    // Command cycle address for each step of a sequence
    function automatic logic [ADDR_W-1:0] step_addr(
        input fbcf_cmd_t c, input logic [1:0] s, input logic bm,
        input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] u1;
        logic [ADDR_W-1:0] u2;
        u1 = bm ? U1_X8 : U1_X16;
        u2 = bm ? U2_X8 : U2_X16;
        case (c)
            FBCF_CMD_RESET3:  step_addr = (s == 2'd1) ? u2 : u1;
            FBCF_CMD_AUTOSEL: begin
                if (s == 2'd0)      step_addr = u1;
                else if (s == 2'd1) step_addr = u2;
                else step_addr = {a[BANK_HI:BANK_LO], u1[18:0]};
            end
            FBCF_CMD_CFI:     step_addr = bm ? CFI_X8 : CFI_X16;
            FBCF_CMD_RESET:   step_addr = u1;
            default:          step_addr = a;
        endcase
    endfunction : step_addr

    // Command byte for each step; upper bits are zero
    function automatic logic [7:0] step_data(
        input fbcf_cmd_t c, input logic [1:0] s);
        case (c)
            FBCF_CMD_RESET:   step_data = D_RESET;
            FBCF_CMD_RESET3:  step_data = (s == 2'd0) ? D_UNLOCK1 :
                                          (s == 2'd1) ? D_UNLOCK2 : D_RESET;
            FBCF_CMD_AUTOSEL: step_data = (s == 2'd0) ? D_UNLOCK1 :
                                          (s == 2'd1) ? D_UNLOCK2 : D_AUTOSEL;
            FBCF_CMD_CFI:     step_data = D_CFI;
            default:          step_data = 8'h00;
        endcase
    endfunction : step_data

    always_comb begin
        is_read   = (cmd_r == FBCF_CMD_READ) || (cmd_r == FBCF_CMD_SIGREAD);
        last_step = ((cmd_r == FBCF_CMD_RESET3) ||
                     (cmd_r == FBCF_CMD_AUTOSEL)) ? (step_r == 2'd2) : 1'b1;
    end

    always_comb begin
        st_nxt   = st_r;
        cmd_nxt  = cmd_r;
        cnt_nxt  = cnt_r;
        idle_nxt = idle_r;
        step_nxt = step_r;
        a_nxt    = a_r;
        lsb_nxt  = lsb_r;
        wd_nxt   = wd_r;
        ce_n_nxt = ce_n_out;
        oe_n_nxt = oe_n_out;
        we_n_nxt = we_n_out;
        hv_nxt   = sig_hv_out;
        aout_nxt = addr_out;
        dqo_nxt  = dq_out;
        dqoe_nxt = dq_oe_out;
        rd_nxt   = rdata_out;
        rdy_nxt  = ready_out;
        done_nxt = 1'b0;
        sby_nxt  = standby_out;
        case (st_r)
            FBCF_ST_IDLE: begin
                if (idle_r != SBY_LAST) idle_nxt = idle_r + 1'b1;
                sby_nxt = (idle_r == SBY_LAST);
                if (req_in) begin
                    cmd_nxt  = fbcf_cmd_t'(cmd_in);
                    a_nxt    = addr_in;
                    lsb_nxt  = lsb_in;
                    wd_nxt   = wdata_in;
                    step_nxt = 2'd0;
                    rdy_nxt  = 1'b0;
                    sby_nxt  = 1'b0;
                    idle_nxt = '0;
                    st_nxt   = FBCF_ST_LOAD;
                end
            end
            FBCF_ST_LOAD: begin
                ce_n_nxt = 1'b0;
                we_n_nxt = 1'b1;
                cnt_nxt  = '0;
                aout_nxt = step_addr(cmd_r, step_r, byte_mode_in, a_r);
                dqo_nxt  = (cmd_r == FBCF_CMD_WRITE) ? wd_r :
                           {8'h00, step_data(cmd_r, step_r)};
                dqoe_nxt = 16'h0000;
                if (is_read) begin
                    oe_n_nxt = 1'b0;
                    hv_nxt   = (cmd_r == FBCF_CMD_SIGREAD);
                end else begin
                    oe_n_nxt = 1'b1;
                    dqoe_nxt = byte_mode_in ? 16'h00ff : 16'hffff;
                end
                if (byte_mode_in) begin
                    dqo_nxt[15]  = lsb_r;
                    dqoe_nxt[15] = 1'b1;
                end
                st_nxt = FBCF_ST_STROBE;
            end
            FBCF_ST_STROBE: begin
                cnt_nxt = cnt_r + 1'b1;
                if (is_read) begin
                    if (cnt_r == READ_LAST) begin
                        rd_nxt   = dq_sync;
                        oe_n_nxt = 1'b1;
                        hv_nxt   = 1'b0;
                        st_nxt   = FBCF_ST_HOLD;
                    end
                end else if (cnt_r == PULSE_LAST) begin
                    we_n_nxt = 1'b1;
                    st_nxt   = FBCF_ST_HOLD;
                end else begin
                    we_n_nxt = 1'b0;
                end
            end
            FBCF_ST_HOLD: begin
                ce_n_nxt = 1'b1;
                dqoe_nxt = 16'h0000;
                st_nxt   = FBCF_ST_GAP;
            end
            FBCF_ST_GAP: begin
                cnt_nxt = '0;
                if (!last_step) begin
                    step_nxt = step_r + 1'b1;
                    st_nxt   = FBCF_ST_LOAD;
                end else if ((cmd_r == FBCF_CMD_RESET) ||
                             (cmd_r == FBCF_CMD_RESET3)) begin
                    st_nxt = FBCF_ST_ABORT;
                end else begin
                    done_nxt = 1'b1;
                    rdy_nxt  = 1'b1;
                    st_nxt   = FBCF_ST_IDLE;
                end
            end
            FBCF_ST_ABORT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == ABORT_LAST) begin
                    done_nxt = 1'b1;
                    rdy_nxt  = 1'b1;
                    st_nxt   = FBCF_ST_IDLE;
                end
            end
            default: st_nxt = FBCF_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r        <= FBCF_ST_IDLE;
            cmd_r       <= FBCF_CMD_READ;
            cnt_r       <= '0;
            idle_r      <= '0;
            step_r      <= 2'd0;
            a_r         <= '0;
            lsb_r       <= 1'b0;
            wd_r        <= '0;
            ce_n_out    <= 1'b1;
            oe_n_out    <= 1'b1;
            we_n_out    <= 1'b1;
            sig_hv_out  <= 1'b0;
            addr_out    <= '0;
            dq_out      <= '0;
            dq_oe_out   <= '0;
            rdata_out   <= '0;
            ready_out   <= 1'b0;
            done_out    <= 1'b0;
            standby_out <= 1'b0;
            byte_n_out  <= 1'b1;
            wp_n_out    <= 1'b0;
            rst_n_out   <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            cmd_r       <= cmd_nxt;
            cnt_r       <= cnt_nxt;
            idle_r      <= idle_nxt;
            step_r      <= step_nxt;
            a_r         <= a_nxt;
            lsb_r       <= lsb_nxt;
            wd_r        <= wd_nxt;
            ce_n_out    <= ce_n_nxt;
            oe_n_out    <= oe_n_nxt;
            we_n_out    <= we_n_nxt;
            sig_hv_out  <= hv_nxt;
            addr_out    <= aout_nxt;
            dq_out      <= dqo_nxt;
            dq_oe_out   <= dqoe_nxt;
            rdata_out   <= rd_nxt;
            ready_out   <= (st_r == FBCF_ST_IDLE) ? ~req_in : rdy_nxt;
            done_out    <= done_nxt;
            standby_out <= sby_nxt;
            byte_n_out  <= ~byte_mode_in;
            wp_n_out    <= ~wp_in;
            rst_n_out   <= 1'b1;
        end
    end

    // Checks on the pin sequencing
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence we_pulse_s;
        $fell(we_n_out) ##0 !ce_n_out;
    endsequence
    sequence abort_end_s;
        st_r == FBCF_ST_ABORT && cnt_r == ABORT_LAST;
    endsequence

    read_pins_a: assert property (
        st_r == FBCF_ST_STROBE && is_read |-> !ce_n_out && !oe_n_out
            && we_n_out) else $error("read pins wrong");
    addr_stable_a: assert property (
        we_pulse_s |-> $stable(addr_out) ##1 $stable(addr_out))
        else $error("address moved during write");
    data_hold_a: assert property (
        $rose(we_n_out) |-> $stable(dq_out) && dq_oe_out != 16'h0000
            && !ce_n_out) else $error("data not held at strobe rise");
    oe_write_a: assert property (
        !we_n_out |-> oe_n_out) else $error("output enable low in write");
    pulse_width_a: assert property (
        $fell(ce_n_out) |-> !ce_n_out[*2]) else $error("select glitch");
    no_contend_a: assert property (
        !oe_n_out |-> dq_oe_out[14:0] == 15'h0000)
        else $error("bus contention on read");
    select_idle_a: assert property (
        ce_n_out |-> we_n_out && dq_oe_out == 16'h0000 ##1 we_n_out)
        else $error("activity while deselected");
    standby_idle_a: assert property (
        standby_out |-> ce_n_out && st_r == FBCF_ST_IDLE)
        else $error("standby while busy");
    abort_done_a: assert property (
        abort_end_s |=> done_out && ready_out && st_r == FBCF_ST_IDLE)
        else $error("abort wait wrong length");
    bank_addr_a: assert property (
        cmd_r == FBCF_CMD_AUTOSEL && step_r == 2'd2 && !we_n_out
            |-> addr_out[BANK_HI:BANK_LO] == a_r[BANK_HI:BANK_LO])
        else $error("auto select bank address wrong");
    cmd_addr_a: assert property (
        cmd_r == FBCF_CMD_RESET3 && step_r == 2'd1 && !we_n_out
            |-> addr_out == (byte_n_out ? U2_X16 : U2_X8))
        else $error("unlock address wrong for bus width");
endmodule : fbcf_host

/* tb/fbcf_flash_model.sv */
// Behavioural four-bank flash: bus decode, command interpreter, codes.
// Assumes a host on its pins; the bench resolves the shared data bus.
`timescale 1ns/100ps
module fbcf_flash_model #(
    parameter int          ACC_NS = 70,
    parameter logic [15:0] MAKER  = 16'h00c1, // Arbitrary value
    parameter logic [15:0] PART   = 16'h7a3d  // Arbitrary value
) (
    // Flash pins
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [20:0] addr_in,
    input  wire logic [15:0] dq_in,
    input  wire logic        byte_n_in,
    input  wire logic        wp_n_in,
    input  wire logic        rst_n_in,
    input  wire logic        sig_hv_in,
    output logic      [15:0] dq_out,
    // Observation
    output logic      [20:0] last_addr_out,
    output logic      [15:0] last_data_out
);
    logic [1:0]  seq_r;
    logic [3:0]  asel_r;
    logic        cfi_r, sel, sel_d, bm, code, prot, u1, u2, cf;
    logic [15:0] word, rd, held;
    logic [20:0] a;
    logic [7:0]  d;
    wire         wr_n = ce_n_in | we_n_in;
    assign bm = ~byte_n_in;
    assign sel = ~ce_n_in & ~oe_n_in & we_n_in;
    assign #(ACC_NS) sel_d = sel;
    always @* begin
        prot = addr_in[18:12] == 7'h05;
        if (!wp_n_in && (addr_in[18:12] == 7'h00 || addr_in[18:12] == 7'h7f))
            prot = 1'b1;
        code = sig_hv_in || (asel_r[addr_in[20:19]] && !cfi_r);
        case (addr_in[1:0])
            2'b00:   word = MAKER;
            2'b01:   word = PART;
            2'b10:   word = {15'h0000, prot};
            default: word = addr_in[6] ? 16'h0000 : 16'h0081;
        endcase
        if (!code && cfi_r)
            word = {8'h00, addr_in[7:0] ^ 8'h3c};
        else if (!code)
            word = addr_in[15:0] ^ 16'h5a3c ^ {11'h000, addr_in[20:16]};
        rd = !bm ? word : {8'h00, (dq_in[15] && !code) ? word[15:8] : word[7:0]};
        if (sel && sel_d)
            held = rd;
        dq_out = (sel && sel_d) ? rd : ~held;
    end
    always @(negedge wr_n) last_addr_out <= addr_in;
    always @(posedge wr_n or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seq_r = 2'h0;
            asel_r = 4'h0;
            cfi_r = 1'b0;
        end else begin
            d = dq_in[7:0];
            a = last_addr_out;
            last_data_out <= dq_in;
            u1 = bm ? a[11:0] == 12'h0aaa : a[10:0] == 11'h555;
            u2 = bm ? a[10:0] == 11'h555 : a[9:0] == 10'h2aa;
            cf = bm ? a[7:0] == 8'haa : a[7:0] == 8'h55;
            if (d == 8'hf0) begin
                if (cfi_r)
                    cfi_r = 1'b0;
                else
                    asel_r = 4'h0;
                seq_r = 2'h0;
            end else if (seq_r == 2'h0 && d == 8'haa && u1)
                seq_r = 2'h1;
            else if (seq_r == 2'h0 && d == 8'h98 && cf)
                cfi_r = 1'b1;
            else if (seq_r == 2'h1 && d == 8'h55 && u2)
                seq_r = 2'h2;
            else if (seq_r == 2'h2 && d == 8'h90) begin
                asel_r[a[20:19]] = 1'b1;
                seq_r = 2'h0;
            end else
                seq_r = 2'h0;
        end
    end
endmodule : fbcf_flash_model

/* tb/flash_bus_command_frontend_tb.sv */
// Self-checking bench for the flash host controller with a flash model.
// Assumes the design package and host module are compiled first.
`timescale 1ns/100ps
module flash_bus_command_frontend_tb;
    import fbcf_pkg::*;
    localparam logic [15:0] MAKER = 16'h00c1; // Arbitrary value
    localparam logic [15:0] PART  = 16'h7a3d; // Arbitrary value
    logic mclk_in, rst_in, req_in, lsb_in, byte_mode_in, wp_in;
    logic ready_out, done_out, standby_out, ce_n_out, oe_n_out, we_n_out;
    logic byte_n_out, wp_n_out, rst_n_out, sig_hv_out;
    logic [2:0]  cmd_in;
    logic [20:0] addr_in, addr_out, l_addr;
    logic [15:0] wdata_in, rdata_out, dq_out, dq_oe_out, m_dq, bus, l_data, w;
    logic [31:0] seed;
    logic [3:0]  asel;
    logic        cfi;
    int          err_total, checks, low_run, cyc, t0;
    assign bus = (dq_oe_out & dq_out) | (~dq_oe_out & m_dq);
    fbcf_host uut (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req_in),
        .cmd_in(cmd_in), .addr_in(addr_in), .lsb_in(lsb_in),
        .wdata_in(wdata_in), .byte_mode_in(byte_mode_in), .wp_in(wp_in),
        .ready_out(ready_out), .done_out(done_out), .rdata_out(rdata_out),
        .standby_out(standby_out), .ce_n_out(ce_n_out), .oe_n_out(oe_n_out),
        .we_n_out(we_n_out), .addr_out(addr_out), .dq_out(dq_out),
        .dq_oe_out(dq_oe_out), .dq_in(bus), .byte_n_out(byte_n_out),
        .wp_n_out(wp_n_out), .rst_n_out(rst_n_out), .sig_hv_out(sig_hv_out));
    fbcf_flash_model #(.ACC_NS(70), .MAKER(MAKER), .PART(PART)) flash (
        .ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out),
        .addr_in(addr_out), .dq_in(bus), .byte_n_in(byte_n_out),
        .wp_n_in(wp_n_out), .rst_n_in(rst_n_out), .sig_hv_in(sig_hv_out),
        .dq_out(m_dq), .last_addr_out(l_addr), .last_data_out(l_data));
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    task automatic summarize();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [15:0] expv(input logic [20:0] a, input logic l,
                                         input logic hv);
        logic [15:0] v;
        logic        cd, pr;
        pr = a[18:12] == 7'h05 || (wp_in && (a[18:12] == 7'h00 || a[18:12] == 7'h7f));
        cd = hv || (asel[a[20:19]] && !cfi);
        if (cd)
            v = (a[1:0] == 2'b00) ? MAKER : (a[1:0] == 2'b01) ? PART
              : (a[1:0] == 2'b10) ? {15'h0000, pr} : (a[6] ? 16'h0000 : 16'h0081);
        else if (cfi)
            v = {8'h00, a[7:0] ^ 8'h3c};
        else
            v = a[15:0] ^ 16'h5a3c ^ {11'h000, a[20:16]};
        if (byte_mode_in)
            v = {8'h00, (l && !cd) ? v[15:8] : v[7:0]};
        return v;
    endfunction : expv
    task automatic op(input logic [2:0] c, input logic [20:0] a,
                      input logic l, input logic [15:0] d);
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < 100) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        if (n >= 100) begin
            chk("ready_out", 16'h0001, 16'h0000);
            summarize();
        end
        cmd_in = c;
        addr_in = a;
        lsb_in = l;
        wdata_in = d;
        req_in = 1'b1;
        @(posedge mclk_in);
        #1;
        req_in = 1'b0;
        while (done_out !== 1'b1 && n < 3000) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        if (n >= 3000) begin
            chk("done_out", 16'h0001, 16'h0000);
            summarize();
        end
        if (c == 3'h4)
            asel[a[20:19]] = 1'b1;
        if (c == 3'h5)
            cfi = 1'b1;
        if ((c == 3'h2 || c == 3'h3) && cfi)
            cfi = 1'b0;
        else if (c == 3'h2 || c == 3'h3)
            asel = 4'h0;
    endtask : op
    task automatic rdc(input logic [20:0] a, input logic l, input logic hv);
        op(hv ? 3'h6 : 3'h0, a, l, 16'h0000);
        chk("rdata", expv(a, l, hv), byte_mode_in ? {8'h00, rdata_out[7:0]} : rdata_out);
    endtask : rdc
    always @(posedge mclk_in) begin
        cyc++;
        if (!rst_in && we_n_out === 1'b0)
            chk("oe_n_in_write", 16'h0001, {15'h0000, oe_n_out});
        if (!rst_in && oe_n_out === 1'b0)
            chk("dq_oe_rd", {byte_mode_in, 15'h0000}, dq_oe_out);
        if (ce_n_out === 1'b1 && low_run > 0)
            chk("ce_low_len", 16'h0001, 16'(low_run >= 2));
        low_run = (ce_n_out === 1'b0) ? low_run + 1 : 0;
    end
    initial begin
        {req_in, lsb_in, wp_in, byte_mode_in, cmd_in, addr_in, wdata_in} = '0;
        {err_total, checks, low_run, cyc, t0, asel, cfi} = '0;
        seed = 32'h5f93_be1b;
        rst_in = 1'b1;
        repeat (2) @(posedge mclk_in);
        #1;
        rst_in = 1'b0;
        @(posedge mclk_in);
        #1;
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            rdc(seed[20:0], 1'b0, 1'b0);
        end
        seed = xs(seed);
        w = {seed[31:24], 8'h00};
        op(3'h1, seed[20:0], 1'b0, w);
        chk("wr_addr", {11'h000, seed[20:16]}, {11'h000, l_addr[20:16]});
        chk("wr_addr_lo", seed[15:0], l_addr[15:0]);
        chk("wr_data", w, l_data);
        op(3'h1, 21'h0_0555, 1'b0, 16'h00aa);
        op(3'h1, 21'h0_0123, 1'b0, 16'h0012);
        op(3'h1, 21'h0_02aa, 1'b0, 16'h0055);
        op(3'h1, 21'h0_0555, 1'b0, 16'h0090);
        rdc(21'h8_0000, 1'b0, 1'b0);
        op(3'h4, 21'h8_0000, 1'b0, 16'h0000);
        for (int i = 0; i < 3; i++)
            rdc({2'b01, 19'h0_0000} | i[20:0], 1'b0, 1'b0);
        rdc(21'h8_5002, 1'b0, 1'b0);
        rdc(21'h8_6002, 1'b0, 1'b0);
        rdc(21'h10_0004, 1'b0, 1'b0);
        wp_in = 1'b1;
        rdc(21'hf_f002, 1'b0, 1'b0);
        wp_in = 1'b0;
        rdc(21'hf_f002, 1'b0, 1'b0);
        repeat (30) @(posedge mclk_in);
        #1;
        chk("standby", 16'h0000, {15'h0000, standby_out});
        repeat (15) @(posedge mclk_in);
        #1;
        chk("standby", 16'h0001, {15'h0000, standby_out});
        rdc(21'h8_0001, 1'b0, 1'b0);
        op(3'h5, 21'h0_0000, 1'b0, 16'h0000);
        rdc(21'h8_0011, 1'b0, 1'b0);
        t0 = cyc;
        op(3'h2, 21'h0_0000, 1'b0, 16'h0000);
        chk("abort", 16'h0001, 16'(cyc - t0 >= ABORT_CYC));
        rdc(21'h8_0000, 1'b0, 1'b0);
        op(3'h3, 21'h0_0000, 1'b0, 16'h0000);
        rdc(21'h8_0000, 1'b0, 1'b0);
        rdc(21'h0_0000, 1'b0, 1'b1);
        rdc(21'h0_0001, 1'b0, 1'b1);
        rdc(21'h0_0003, 1'b0, 1'b1);
        byte_mode_in = 1'b1;
        op(3'h4, 21'h10_0000, 1'b0, 16'h0000);
        seed = xs(seed);
        rdc(21'h10_0000, seed[0], 1'b0);
        rdc(21'h10_0001, 1'b1, 1'b0);
        op(3'h2, 21'h0_0000, 1'b0, 16'h0000);
        rdc(21'h1_0246, 1'b0, 1'b0);
        rdc(21'h1_0246, 1'b1, 1'b0);
        summarize();
    end
endmodule : flash_bus_command_frontend_tb
